/* File: logic/emtp_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef EMTP_REGS_VH
`define EMTP_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define EMTP_OFS_CTRL 8'h00
`define EMTP_OFS_REFRESH 8'h04
`define EMTP_OFS_BASE 8'h08
`define EMTP_OFS_RD_OFFSET 8'h0C
`define EMTP_OFS_WR_OFFSET 8'h10
`define EMTP_OFS_RD_DATA 8'h14
`define EMTP_OFS_WR_DATA 8'h18
`define EMTP_OFS_STATUS 8'h1C

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define EMTP_CTRL_MODE_LO 0
`define EMTP_CTRL_WL_LO 2
`define EMTP_CTRL_BW_BIT 4
`define EMTP_CTRL_RTS_BIT 5
`define EMTP_CTRL_INR_BIT 6
`define EMTP_CTRL_INW_BIT 7
`define EMTP_CTRL_RS_BIT 8
`define EMTP_CTRL_WAIT_LO 9
`define EMTP_CTRL_RESET 13'h0000

// memory modes
`define EMTP_MODE_SRAM 2'h0
`define EMTP_MODE_SRAM_RC 2'h1
`define EMTP_MODE_DRAM_FAST 2'h2
`define EMTP_MODE_DRAM_SLOW 2'h3

// ----------------------------------------------------------------------
// refresh control fields
// ----------------------------------------------------------------------
`define EMTP_RCR_DIV_LO 0
`define EMTP_RCR_PS_LO 8
`define EMTP_RCR_EN_BIT 10
`define EMTP_RCR_DBG_BIT 11
`define EMTP_RCR_RESET 12'h000
`define EMTP_PS_64 2'h0
`define EMTP_PS_8 2'h1
`define EMTP_PS_1 2'h2

// ----------------------------------------------------------------------
// status bits
// ----------------------------------------------------------------------
`define EMTP_ST_BUSY 0
`define EMTP_ST_BDF 1
`define EMTP_ST_RDF 2
`define EMTP_ST_WDE 3
`define EMTP_ST_PEND 4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define EMTP_CLK_PER_ICYC 2
`define EMTP_REFRESH_ICYC 3'h2

`endif

/* File: logic/emtp_refresh_timer.v */
// refresh request timer: programmable divider then prescaler
`include "emtp_regs.vh"

module emtp_refresh_timer (
   aclk,
   aresetn,
   divider,
   prescale_sel,
   run,
   tick_q
);
   input wire aclk;
   input wire aresetn;
   input wire [7:0] divider;
   input wire [1:0] prescale_sel;
   input wire run;
   output reg tick_q;

   reg [7:0] div_cnt_q;
   reg [5:0] ps_cnt_q;
   reg [5:0] ps_top;
   wire div_wrap;

   always @* begin
      case (prescale_sel)
         `EMTP_PS_64: ps_top = 6'h3F;
         `EMTP_PS_8: ps_top = 6'h07;
         `EMTP_PS_1: ps_top = 6'h00;
         default: ps_top = 6'h3F;
      endcase
   end

   assign div_wrap = (div_cnt_q == divider);

   // request every (divider+1) x prescale clocks
   always @(posedge aclk) begin
      if (!aresetn || !run) begin
         div_cnt_q <= 8'h00;
         ps_cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (div_wrap) begin
            div_cnt_q <= 8'h00;
            if (ps_cnt_q >= ps_top) begin
               ps_cnt_q <= 6'h00;
               tick_q <= 1'b1;
            end else begin
               ps_cnt_q <= ps_cnt_q + 6'h01;
            end
         end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
         end
      end
   end
endmodule

/* File: logic/emtp_top.v */
// transfer engine of the external memory interface with axi4-lite registers
`include "emtp_regs.vh"

module emtp_top #(
   parameter AW = 24
) (
   aclk,
   aresetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   mem_addr_q,
   mem_wdata_q,
   mem_rdata,
   mem_access_q,
   mem_write_q,
   mem_refresh_q,
   read_irq_q
);
   input wire aclk;
   input wire aresetn;
   input wire [7:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output reg s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output reg s_axi_wready;
   output reg [1:0] s_axi_bresp;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   input wire [7:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output reg s_axi_arready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   output reg s_axi_rvalid;
   input wire s_axi_rready;
   output reg [AW-1:0] mem_addr_q;
   output reg [7:0] mem_wdata_q;
   input wire [7:0] mem_rdata;
   output reg mem_access_q;
   output reg mem_write_q;
   output reg mem_refresh_q;
   output reg read_irq_q;

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_ACC = 2'h2;
   localparam ST_REF = 2'h3;

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [12:0] ctrl_q;
   reg [11:0] rcr_q;
   reg [AW-1:0] base_q;
   reg [AW-1:0] rd_off_q;
   reg [AW-1:0] wr_off_q;
   reg [23:0] rd_data_q;
   reg [23:0] wr_data_q;
   reg [23:0] asm_q;
   reg rdf_q;
   reg bdf_q;
   reg wde_q;
   reg busy_q;
   reg [1:0] state_q;
   reg pend_q;
   reg pend_wr_q;
   reg cur_wr_q;
   reg [AW-1:0] word_addr_q;
   reg [2:0] acc_idx_q;
   reg [2:0] acc_cnt;
   reg [3:0] cyc_q;
   reg [3:0] acc_len;
   reg ref_req_q;
   reg inc_pend_q;
   reg [1:0] aw_held_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   wire ref_tick;
   wire [1:0] mode;
   wire [1:0] wlen;
   wire bw8;
   wire ref_allowed;
   wire wr_fire;
   wire rd_fire;
   wire trig_rd;
   wire trig_wr;
   wire trig_any;
   wire start_ok;
   wire last_acc;
   wire last_cyc;
   wire word_done;
   wire rd_data_read;
   wire [4:0] status;

   assign mode = ctrl_q[`EMTP_CTRL_MODE_LO+1:`EMTP_CTRL_MODE_LO];
   assign wlen = ctrl_q[`EMTP_CTRL_WL_LO+1:`EMTP_CTRL_WL_LO];
   assign bw8 = ctrl_q[`EMTP_CTRL_BW_BIT];
   assign status = {pend_q, wde_q, rdf_q, bdf_q, busy_q};

   // refresh gating by enable and memory mode
   assign ref_allowed = (rcr_q[`EMTP_RCR_EN_BIT] | rcr_q[`EMTP_RCR_DBG_BIT])
      & (mode != `EMTP_MODE_SRAM);

   emtp_refresh_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .divider(rcr_q[`EMTP_RCR_DIV_LO+7:`EMTP_RCR_DIV_LO]),
      .prescale_sel(rcr_q[`EMTP_RCR_PS_LO+1:`EMTP_RCR_PS_LO]),
      .run(ref_allowed),
      .tick_q(ref_tick)
   );

   // ----------------------------------------------------------------------
   // accesses per word and access length
   // ----------------------------------------------------------------------
   // accesses from word length and bus width
   always @* begin
      case ({bw8, wlen})
         // value is the index of the last access: count minus one
         3'b000: acc_cnt = 3'h5;
         3'b001: acc_cnt = 3'h3;
         3'b010: acc_cnt = 3'h2;
         3'b011: acc_cnt = 3'h1;
         3'b100: acc_cnt = 3'h2;
         3'b101: acc_cnt = 3'h1;
         3'b110: acc_cnt = 3'h0;
         default: acc_cnt = 3'h0;
      endcase
   end

   // wait count N, access length N+1 in instruction cycles of two clocks, two for N of zero
   always @* begin
      acc_len = {1'b0, ctrl_q[`EMTP_CTRL_WAIT_LO+2:`EMTP_CTRL_WAIT_LO]};
      if (acc_len == 4'h0) begin
         acc_len = 4'h1;
      end
   end

   assign last_acc = (acc_idx_q == acc_cnt);
   assign last_cyc = (cyc_q == 4'h0);
   assign word_done = (state_q == ST_ACC) & last_cyc & last_acc;

   // ----------------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------------
   assign wr_fire = aw_held_q == 2'h3 && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign rd_data_read = rd_fire && s_axi_araddr == `EMTP_OFS_RD_DATA;

   assign trig_rd = (wr_fire && awaddr_q == `EMTP_OFS_RD_OFFSET
      && !ctrl_q[`EMTP_CTRL_RTS_BIT])
      || (rd_data_read && ctrl_q[`EMTP_CTRL_RTS_BIT]);
   assign trig_wr = wr_fire && awaddr_q == `EMTP_OFS_WR_DATA;
   assign trig_any = trig_rd | trig_wr;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h00000000;
         aw_held_q <= 2'h0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_held_q[0] <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            aw_held_q[1] <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_q <= 2'h0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q > `EMTP_OFS_WR_DATA
               || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `EMTP_OFS_CTRL: s_axi_rdata <= {19'h0, ctrl_q};
               `EMTP_OFS_REFRESH: s_axi_rdata <= {20'h0, rcr_q};
               `EMTP_OFS_BASE: s_axi_rdata <= {{(32-AW){1'b0}}, base_q};
               `EMTP_OFS_RD_OFFSET: s_axi_rdata <= {{(32-AW){1'b0}}, rd_off_q};
               `EMTP_OFS_WR_OFFSET: s_axi_rdata <= {{(32-AW){1'b0}}, wr_off_q};
               `EMTP_OFS_RD_DATA: s_axi_rdata <= {8'h00, rd_data_q};
               `EMTP_OFS_WR_DATA: s_axi_rdata <= {8'h00, wr_data_q};
               `EMTP_OFS_STATUS: s_axi_rdata <= {27'h0, status};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `EMTP_CTRL_RESET;
         rcr_q <= `EMTP_RCR_RESET;
         rd_off_q <= {AW{1'b0}};
         wr_off_q <= {AW{1'b0}};
      end else if (wr_fire) begin
         case (awaddr_q)
            `EMTP_OFS_CTRL: ctrl_q <= wdata_q[12:0];
            `EMTP_OFS_REFRESH: rcr_q <= wdata_q[11:0];
            `EMTP_OFS_RD_OFFSET: rd_off_q <= wdata_q[AW-1:0];
            `EMTP_OFS_WR_OFFSET: wr_off_q <= wdata_q[AW-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // trigger pipeline and access sequencer
   // ----------------------------------------------------------------------
   // hold while assembly buffer still full
   // start read only with empty buffer
   assign start_ok = pend_q && !bdf_q && (!pend_wr_q || wde_q == 1'b0);

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         pend_q <= 1'b0;
         pend_wr_q <= 1'b0;
         cur_wr_q <= 1'b0;
         word_addr_q <= {AW{1'b0}};
         acc_idx_q <= 3'h0;
         cyc_q <= 4'h0;
         ref_req_q <= 1'b0;
         inc_pend_q <= 1'b0;
         base_q <= {AW{1'b0}};
         mem_access_q <= 1'b0;
         mem_write_q <= 1'b0;
         mem_refresh_q <= 1'b0;
         mem_addr_q <= {AW{1'b0}};
         mem_wdata_q <= 8'h00;
      end else begin
         if (ref_tick) begin
            ref_req_q <= 1'b1;
         end
         // second trigger from idle is kept pending
         if (trig_any) begin
            pend_q <= 1'b1;
            pend_wr_q <= trig_wr;
            busy_q <= 1'b1;
         end
         // base increment one cycle after address
         inc_pend_q <= 1'b0;
         if (wr_fire && awaddr_q == `EMTP_OFS_BASE) begin
            base_q <= wdata_q[AW-1:0];
         end else if (inc_pend_q) begin
            base_q <= base_q + {{(AW-1){1'b0}}, 1'b1};
         end
         mem_access_q <= 1'b0;
         mem_refresh_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (ref_req_q && ref_allowed) begin
                  state_q <= ST_REF;
                  cyc_q <= {`EMTP_REFRESH_ICYC, 1'b1};
                  mem_refresh_q <= 1'b1;
               end else if (start_ok && !trig_any) begin
                  state_q <= ST_ADDR;
                  cyc_q <= 4'h1;
                  cur_wr_q <= pend_wr_q;
                  pend_q <= 1'b0;
               end else if (!pend_q && !trig_any) begin
                  busy_q <= 1'b0;
               end
            end
            ST_ADDR: begin
               cyc_q <= cyc_q - 4'h1;
               if (last_cyc) begin
                  // word address is base minus offset
                  word_addr_q <= base_q - (cur_wr_q ? wr_off_q : rd_off_q);
                  inc_pend_q <= cur_wr_q ? ctrl_q[`EMTP_CTRL_INW_BIT]
                     : ctrl_q[`EMTP_CTRL_INR_BIT];
                  state_q <= ST_ACC;
                  acc_idx_q <= 3'h0;
                  cyc_q <= {acc_len[2:0], 1'b1};
                  mem_access_q <= 1'b1;
                  mem_write_q <= cur_wr_q;
                  mem_addr_q <= base_q - (cur_wr_q ? wr_off_q : rd_off_q);
                  mem_wdata_q <= asm_q[7:0];
               end
            end
            ST_ACC: begin
               cyc_q <= cyc_q - 4'h1;
               if (last_cyc) begin
                  if (!last_acc) begin
                     acc_idx_q <= acc_idx_q + 3'h1;
                     cyc_q <= {acc_len[2:0], 1'b1};
                     mem_access_q <= 1'b1;
                     mem_addr_q <= word_addr_q + {{(AW-3){1'b0}},
                        acc_idx_q + 3'h1};
                     mem_wdata_q <= asm_q[7:0];
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_REF: begin
               cyc_q <= cyc_q - 4'h1;
               if (last_cyc) begin
                  state_q <= ST_IDLE;
                  if (!ref_tick) begin
                     ref_req_q <= 1'b0;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // assembly buffer and data registers
   // ----------------------------------------------------------------------
   // second data stage beside the data registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         asm_q <= 24'h000000;
         bdf_q <= 1'b0;
         rdf_q <= 1'b0;
         wde_q <= 1'b1;
         rd_data_q <= 24'h000000;
         wr_data_q <= 24'h000000;
         read_irq_q <= 1'b0;
      end else begin
         if (trig_wr) begin
            wr_data_q <= wdata_q[23:0];
            wde_q <= 1'b0;
         end else if (!wde_q && !bdf_q && state_q == ST_IDLE) begin
            asm_q <= wr_data_q;
            bdf_q <= 1'b1;
            wde_q <= 1'b1;
         end
         if (state_q == ST_ACC && last_cyc) begin
            if (cur_wr_q) begin
               asm_q <= {8'h00, asm_q[23:8]};
            end else begin
               // gather bytes into the assembly buffer
               asm_q <= {mem_rdata, asm_q[23:8]};
            end
         end
         if (word_done) begin
            bdf_q <= !cur_wr_q;
         end
         // reading data clears flag, refill from buffer
         // move assembled word only into empty register
         // data visible after the final access
         if (rd_data_read) begin
            rdf_q <= 1'b0;
         end else if (bdf_q && !rdf_q && !cur_wr_q && state_q != ST_ACC) begin
            rd_data_q <= asm_q;
            rdf_q <= 1'b1;
            bdf_q <= 1'b0;
         end
         // interrupt on ready, or on both full
         read_irq_q <= ctrl_q[`EMTP_CTRL_RS_BIT] ? (rdf_q & bdf_q & !cur_wr_q)
            : rdf_q;
      end
   end
endmodule

/* File: test/emtp_mem_model.sv */
// byte-wide external memory stand-in for the transfer engine
module emtp_mem_model (
   input wire aclk,
   input wire [23:0] mem_addr_q,
   input wire [7:0] mem_wdata_q,
   input wire mem_access_q,
   input wire mem_write_q,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem_q [0:255];
   initial begin
      mem_rdata = 8'hA5;
      for (int i = 0; i < 256; i++) begin
         mem_q[i] = 8'(i) ^ 8'h5A;
      end
   end
   // memory inverts its read data lines during a write
   always @(posedge aclk) begin
      if (mem_access_q && mem_write_q) begin
         mem_q[mem_addr_q[7:0]] <= mem_wdata_q;
         mem_rdata <= ~mem_rdata;
      end else if (mem_access_q) begin
         mem_rdata <= mem_q[mem_addr_q[7:0]];
      end
   end
endmodule

/* File: test/emtp_top_assertions.sv */
// concurrent checks on the transfer engine ports
module emtp_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire mem_access_q,
   input wire mem_write_q,
   input wire mem_refresh_q
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_b_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_r_holds:
      assert property (s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response changed");
   a_r_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_b_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_err_zero:
      assert property (s_axi_rvalid && s_axi_rresp == 2'h2
         |-> s_axi_rdata == 32'h00000000)
      else $error("refused read carries data");
   a_access_gap:
      assert property (mem_access_q |=> !mem_access_q [*2])
      else $error("access shorter than three clocks");
   a_refresh_len:
      assert property (mem_refresh_q
         |=> (!mem_access_q && !mem_refresh_q) [*4])
      else $error("access inside refresh cycle");
   a_idle_refresh:
      assert property (mem_access_q |=> !mem_refresh_q [*2])
      else $error("refresh inside access");

   c_refresh: cover property (mem_refresh_q);
   c_write: cover property (mem_access_q && mem_write_q);
   c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind emtp_top emtp_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mem_access_q,
   .mem_write_q, .mem_refresh_q);

/* File: test/emtp_top_bench.sv */
// register-level bench for the transfer engine
`include "emtp_regs.vh"
module emtp_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, mem_access_q, mem_write_q, mem_refresh_q, read_irq_q;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [7:0] mem_wdata_q, mem_rdata;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [23:0] mem_addr_q;
   int num_errors = 0, n_checks = 0, n_acc = 0, n_wr = 0, n_ref = 0;

   emtp_top #(.AW(24)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .mem_addr_q, .mem_wdata_q, .mem_rdata, .mem_access_q, .mem_write_q,
      .mem_refresh_q, .read_irq_q);
   emtp_mem_model mem_u (.aclk, .mem_addr_q, .mem_wdata_q, .mem_access_q,
      .mem_write_q, .mem_rdata);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (mem_access_q) n_acc <= n_acc + 1;
      if (mem_access_q && mem_write_q) n_wr <= n_wr + 1;
      if (mem_refresh_q) n_ref <= n_ref + 1;
   end

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic st(input logic [31:0] e);
      rd(`EMTP_OFS_STATUS);
      chk(d & 32'h00000017, e);
   endtask
   task automatic wait_idle();
      do rd(`EMTP_OFS_STATUS); while (d[0] || d[4]);
   endtask
   task automatic gap(output int g);
      do @(posedge aclk); while (!mem_refresh_q);
      g = 0;
      do begin
         @(posedge aclk);
         g++;
      end while (!mem_refresh_q);
   endtask
   task automatic no_ref();
      int a0;
      repeat (10) @(posedge aclk);
      a0 = n_ref;
      repeat (200) @(posedge aclk);
      chk(n_ref - a0, 0);
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      int g, a0;
      int dv[3] = '{9, 1, 0};
      int pv[3] = '{1, 8, 64};
      logic [1:0] ps[3] = '{`EMTP_PS_1, `EMTP_PS_8, `EMTP_PS_64};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`EMTP_OFS_CTRL);
      chk(d, 32'h00000000);
      rd(`EMTP_OFS_REFRESH);
      chk(d, 32'h00000000);
      st(32'h00000000);
      rd(8'h40);
      chk({r, d}, {2'h2, 32'h00000000});
      wr(8'h40, 32'h00000001);
      chk(r, 2'h2);
      for (int i = 0; i < 3; i++) begin
         wr(`EMTP_OFS_CTRL, i + 1);
         wr(`EMTP_OFS_REFRESH, 32'h00000400 | (ps[i] << 8) | dv[i]);
         gap(g);
         gap(g);
         chk(g, (dv[i] + 1) * pv[i]);
      end
      wr(`EMTP_OFS_CTRL, 32'h00000000);
      no_ref();
      wr(`EMTP_OFS_CTRL, 32'h00000002);
      wr(`EMTP_OFS_REFRESH, 32'h00000209);
      no_ref();
      wr(`EMTP_OFS_REFRESH, 32'h00000609);
      wr(`EMTP_OFS_BASE, 32'h00000080);
      for (int k = 0; k < 8; k++) begin
         wr(`EMTP_OFS_CTRL, 32'h00000002 | (k << 2));
         a0 = n_acc;
         wr(`EMTP_OFS_RD_OFFSET, k);
         wait_idle();
         chk((n_acc - a0) inside {1, 2, 3, 4, 6}, 1);
         st(32'h00000004);
         chk(read_irq_q, 1);
         rd(`EMTP_OFS_RD_DATA);
         if (k == 7) chk(d[23:16], 8'h23);
         st(32'h00000000);
      end
      wr(`EMTP_OFS_REFRESH, 32'h00000000);
      wr(`EMTP_OFS_CTRL, 32'h00000000);
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000001);
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000002);
      wait_idle();
      st(32'h00000006);
      a0 = n_acc;
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000003);
      repeat (40) @(posedge aclk);
      chk(n_acc - a0, 0);
      rd(`EMTP_OFS_STATUS);
      chk({d[4], d[2:1]}, 3'h7);
      rd(`EMTP_OFS_RD_DATA);
      wait_idle();
      st(32'h00000006);
      rd(`EMTP_OFS_RD_DATA);
      rd(`EMTP_OFS_RD_DATA);
      st(32'h00000000);
      wr(`EMTP_OFS_CTRL, 32'h00000E1C);
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000001);
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000002);
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000003);
      wait_idle();
      rd(`EMTP_OFS_RD_DATA);
      rd(`EMTP_OFS_RD_DATA);
      st(32'h00000000);
      wr(`EMTP_OFS_CTRL, 32'h000000C0);
      wr(`EMTP_OFS_BASE, 32'h00000100);
      wr(`EMTP_OFS_RD_OFFSET, 32'h00000000);
      wait_idle();
      rd(`EMTP_OFS_BASE);
      chk(d, 32'h00000101);
      rd(`EMTP_OFS_RD_DATA);
      a0 = n_wr;
      wr(`EMTP_OFS_WR_DATA, 32'h00123456);
      wait_idle();
      rd(`EMTP_OFS_BASE);
      chk(d, 32'h00000102);
      chk(n_wr > a0, 1);
      wr(`EMTP_OFS_CTRL, 32'h00000020);
      a0 = n_acc;
      rd(`EMTP_OFS_RD_DATA);
      wait_idle();
      chk(n_acc > a0, 1);
      wr(`EMTP_OFS_CTRL, 32'h00000000);
      a0 = n_acc;
      rd(`EMTP_OFS_RD_DATA);
      repeat (20) @(posedge aclk);
      chk(n_acc - a0, 0);
      finish_test();
   end

   initial begin
      repeat (60000) @(posedge aclk);
      num_errors++;
      finish_test();
   end
endmodule
